// ===== rtl/dtc_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: apb byte addresses, 32-bit aligned registers
// Notes: mode register copies are written by software over apb
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
`define DTC_OFF_MODE0 12'h000
`define DTC_OFF_MODE1 12'h004
`define DTC_OFF_MODE2 12'h008
`define DTC_OFF_LAT 12'h00c
`define DTC_OFF_CTRL 12'h010
`define DTC_OFF_STAT 12'h014
`define DTC_A2 2
`define DTC_A6 6
`define DTC_A9 9
`define DTC_A10 10
`define DTC_A12 12
`define DTC_LAT_CWL_LSB 0
`define DTC_LAT_AL_LSB 8
`define DTC_CTRL_SREF 0
`define DTC_CTRL_PPD 1
`define DTC_MODE_RST 13'h0000
`define DTC_LAT_RST 5'h05
`define DTC_HIGH_SHORT 4
`define DTC_HIGH_LONG 6
`define DTC_LAT_OFS 2
`endif

// ===== rtl/dtc_pkg.sv
// Purpose: types shared by the termination control logic
// Assumes: dtc_map.svh holds the numbers
// Notes: none
package dtc_pkg;
  typedef logic [4:0] dtc_lat_t;
  typedef logic [31:0] dtc_hist_t;
  typedef enum logic [1:0] {
    DTC_ST_OFF = 2'b00,
    DTC_ST_NOM = 2'b01,
    DTC_ST_WR = 2'b11
  } dtc_term_e;
  typedef struct packed {
    logic [12:0] mode0;
    logic [12:0] mode1;
    logic [12:0] mode2;
    dtc_lat_t write_cas_latency;
    dtc_lat_t al;
    logic sref;
    logic ppd;
  } dtc_cfg_s;
  typedef struct packed {
    logic [2:0] pin_sync;
    logic pin_q;
    dtc_hist_t pin_hist;
    dtc_hist_t wr_hist;
    dtc_hist_t bc4_hist;
    logic term_on;
    logic wr_str;
    logic [2:0] byte_term;
    logic [2:0] nom_sel;
    logic [1:0] wr_sel;
    dtc_term_e state;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic viol;
    logic [2:0] high_cnt;
  } dtc_state_s;
endpackage : dtc_pkg

// ===== rtl/dtc_term_ctrl.sv
// Purpose: termination on/off and strength control of a x16 sdram
// Assumes: pin and write strobe from the controller; apb configuration
// Notes: latency measured in pclk cycles; half-cycle points rounded up
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "dtc_map.svh"
module dtc_term_ctrl
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // controller side
  input wire logic term_control_pin,
  input wire logic write_cmd,
  input wire logic write_bc4,
  input wire logic dll_locked,
  input wire logic drivers_active,
  // termination outputs
  output logic [2:0] term_lane_en,
  output logic write_strength_sel,
  output logic [2:0] nominal_termination,
  output logic [1:0] write_termination,
  output logic hold_violation
);
  // configuration copy and live state
  dtc_cfg_s cfg_reg;
  dtc_cfg_s cfg_next;
  dtc_state_s st_reg;
  dtc_state_s st_next;

  // mode decode
  logic nom_any;
  logic wr_any;
  logic term_en;
  logic dyn_en;
  logic async_mode;

  // latency arithmetic
  logic [5:0] lsum;
  dtc_lat_t wl2;
  dtc_lat_t lat;
  dtc_lat_t lat4;
  dtc_lat_t lat6;

  // bus decode
  logic apb_setup;
  logic apb_commit;
  logic apb_wr;
  logic apb_rd;
  logic wr_mode0;
  logic wr_mode1;
  logic wr_mode2;
  logic wr_lat;
  logic wr_ctrl;
  logic rd_stat;
  logic [31:0] rd_word;
  logic rd_err;

  // pin path and delay lines
  logic pin_agree;
  logic pin_level;
  logic pin_gated;
  dtc_hist_t pin_hist_next;
  dtc_hist_t wr_hist_next;
  dtc_hist_t bc4_hist_next;
  wire [31:0] tap_on;
  wire [31:0] tap_wr_win;
  logic on_ph;
  logic wr_ph;
  logic term_on_next;
  logic wr_str_next;
  wire [2:0] lane_next;

  always_comb begin
    // any nominal or write strength bit enables termination
    nom_any = cfg_reg.mode1[`DTC_A2] | cfg_reg.mode1[`DTC_A6] |
      cfg_reg.mode1[`DTC_A9];
    wr_any = cfg_reg.mode2[`DTC_A9] | cfg_reg.mode2[`DTC_A10];
    term_en = nom_any | wr_any;
    dyn_en = wr_any;

    // dll frozen in precharge power-down: no posted latency
    async_mode = cfg_reg.ppd & ~cfg_reg.mode0[`DTC_A12];

    // sum kept one bit wider so that cwl + al cannot wrap
    lsum = 6'(cfg_reg.write_cas_latency) + 6'(cfg_reg.al);
    if (lsum > 6'(`DTC_LAT_OFS)) begin
      wl2 = 5'(lsum - 6'(`DTC_LAT_OFS));
    end else begin
      wl2 = 5'h00;
    end

    // half-cycle points are rounded onto the whole edge
    if (async_mode) begin
      lat = 5'h00;
    end else begin
      lat = wl2;
    end
    // strength window ends four or six past the switch point
    lat4 = 5'(lat + 5'(`DTC_HIGH_SHORT));
    lat6 = 5'(lat + 5'(`DTC_HIGH_LONG));
  end

  // apb: pready answers the setup cycle, the access edge commits
  always_comb begin
    apb_setup = psel & ~penable;
    apb_commit = psel & penable & st_reg.pready;
    apb_wr = apb_commit & pwrite;
    apb_rd = apb_commit & ~pwrite;
    wr_mode0 = apb_wr & (paddr == `DTC_OFF_MODE0);
    wr_mode1 = apb_wr & (paddr == `DTC_OFF_MODE1);
    wr_mode2 = apb_wr & (paddr == `DTC_OFF_MODE2);
    wr_lat = apb_wr & (paddr == `DTC_OFF_LAT);
    wr_ctrl = apb_wr & (paddr == `DTC_OFF_CTRL);
    rd_stat = apb_rd & (paddr == `DTC_OFF_STAT);
  end

  // read mux; unmapped addresses answer zero with an error
  always_comb begin
    rd_word = 32'h0;
    rd_err = 1'b0;
    case (paddr)
      `DTC_OFF_MODE0: begin
        rd_word[12:0] = cfg_reg.mode0;
      end
      `DTC_OFF_MODE1: begin
        rd_word[12:0] = cfg_reg.mode1;
      end
      `DTC_OFF_MODE2: begin
        rd_word[12:0] = cfg_reg.mode2;
      end
      `DTC_OFF_LAT: begin
        rd_word[`DTC_LAT_CWL_LSB +: 5] = cfg_reg.write_cas_latency;
        rd_word[`DTC_LAT_AL_LSB +: 5] = cfg_reg.al;
      end
      `DTC_OFF_CTRL: begin
        rd_word[`DTC_CTRL_SREF] = cfg_reg.sref;
        rd_word[`DTC_CTRL_PPD] = cfg_reg.ppd;
      end
      `DTC_OFF_STAT: begin
        rd_word[0] = dyn_en;
        rd_word[1] = term_en;
        rd_word[2] = st_reg.pin_q;
        rd_word[3] = st_reg.term_on;
        rd_word[4] = st_reg.wr_str;
        rd_word[6:5] = st_reg.state;
        rd_word[7] = st_reg.viol;
        // lock is reported only; sync timing follows the mode bits
        rd_word[8] = dll_locked;
      end
      default: begin
        // a write here is dropped, a read returns zero
        rd_err = 1'b1;
      end
    endcase
  end

  // third and second stages must agree before a change counts
  always_comb begin
    pin_agree = st_reg.pin_sync[2] == st_reg.pin_sync[1];
    pin_level = pin_agree ? st_reg.pin_sync[2] : st_reg.pin_q;
    // an ignored pin never enters the delay line
    pin_gated = st_reg.pin_q & term_en & ~cfg_reg.sref;
  end

  // histories shift every edge; latency picks the tap
  always_comb begin
    pin_hist_next = {st_reg.pin_hist[30:0], pin_gated};
    // only writes that can switch strength are recorded
    wr_hist_next = {st_reg.wr_hist[30:0], write_cmd & dyn_en};
    bc4_hist_next = {st_reg.bc4_hist[30:0], write_bc4};
  end

  // per tap: on point of the pin and strength window of a write
  for (genvar g = 0; g < 32; g++) begin : g_tap
    localparam dtc_lat_t TAP = 5'(g);
    dtc_lat_t win_end;
    assign win_end = bc4_hist_next[g] ? lat4 : lat6;
    assign tap_on[g] = pin_hist_next[g] & (TAP == lat);
    assign tap_wr_win[g] = wr_hist_next[g] & (TAP >= lat) &
      (TAP < win_end);
  end

  always_comb begin
    on_ph = |tap_on;
    wr_ph = |tap_wr_win;
  end

  // drivers win: termination waits for output release
  always_comb begin
    term_on_next = on_ph & ~drivers_active;
    wr_str_next = wr_ph & dyn_en & term_en;
    if (!term_en || cfg_reg.sref) begin
      term_on_next = 1'b0;
      wr_str_next = 1'b0;
    end
  end

  // every lane follows the one control
  for (genvar l = 0; l < 3; l++) begin : g_lane
    assign lane_next[l] = term_on_next;
  end

  always_comb begin
    cfg_next = cfg_reg;
    st_next = st_reg;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;

    // bus answer and configuration writes
    if (apb_setup) begin
      st_next.pready = 1'b1;
      st_next.prdata = rd_word;
      st_next.pslverr = rd_err;
    end
    if (wr_mode0) begin
      cfg_next.mode0 = pwdata[12:0];
    end
    if (wr_mode1) begin
      cfg_next.mode1 = pwdata[12:0];
    end
    if (wr_mode2) begin
      cfg_next.mode2 = pwdata[12:0];
    end
    if (wr_lat) begin
      cfg_next.write_cas_latency = pwdata[`DTC_LAT_CWL_LSB +: 5];
      cfg_next.al = pwdata[`DTC_LAT_AL_LSB +: 5];
    end
    if (wr_ctrl) begin
      cfg_next.sref = pwdata[`DTC_CTRL_SREF];
      cfg_next.ppd = pwdata[`DTC_CTRL_PPD];
    end

    // reading status clears the sticky flag
    if (rd_stat) begin
      st_next.viol = 1'b0;
    end

    // pin synchroniser and delay lines
    st_next.pin_sync = {st_reg.pin_sync[1:0], term_control_pin};
    st_next.pin_q = pin_level;
    st_next.pin_hist = pin_hist_next;
    st_next.wr_hist = wr_hist_next;
    st_next.bc4_hist = bc4_hist_next;

    // termination and strength
    st_next.term_on = term_on_next;
    st_next.wr_str = wr_str_next;
    st_next.byte_term = lane_next;

    // strength codes are passed on as programmed
    st_next.nom_sel[2] = cfg_reg.mode1[`DTC_A9];
    st_next.nom_sel[1] = cfg_reg.mode1[`DTC_A6];
    st_next.nom_sel[0] = cfg_reg.mode1[`DTC_A2];
    st_next.wr_sel[1] = cfg_reg.mode2[`DTC_A10];
    st_next.wr_sel[0] = cfg_reg.mode2[`DTC_A9];
    if (!term_on_next) begin
      st_next.state = DTC_ST_OFF;
    end else if (wr_str_next) begin
      st_next.state = DTC_ST_WR;
    end else begin
      st_next.state = DTC_ST_NOM;
    end

    // minimum high time watch on the pin, sticky until status read
    if (st_reg.pin_q) begin
      // saturates: only short pulses matter
      if (st_reg.high_cnt != 3'h7) begin
        st_next.high_cnt = 3'(st_reg.high_cnt + 3'h1);
      end
    end else begin
      st_next.high_cnt = 3'h0;
    end
    // a short pulse is only flagged, the pin still acts on it
    if (st_reg.pin_q && !pin_level && term_en &&
        st_reg.high_cnt < 3'(`DTC_HIGH_SHORT - 1)) begin
      st_next.viol = 1'b1; // set wins over read clear
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg.mode0 <= `DTC_MODE_RST;
      cfg_reg.mode1 <= `DTC_MODE_RST;
      cfg_reg.mode2 <= `DTC_MODE_RST;
      cfg_reg.write_cas_latency <= `DTC_LAT_RST;
      cfg_reg.al <= 5'h00;
      cfg_reg.sref <= 1'b0;
      cfg_reg.ppd <= 1'b0;
      st_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
      st_reg <= st_next;
    end
  end

  // bus answer, straight from the state register
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;

  // termination control outputs
  assign term_lane_en = st_reg.byte_term;
  assign write_strength_sel = st_reg.wr_str;
  assign nominal_termination = st_reg.nom_sel;
  assign write_termination = st_reg.wr_sel;

  // status
  assign hold_violation = st_reg.viol;
endmodule : dtc_term_ctrl

// ===== test/dtc_ctrl_model.sv
// Purpose: memory controller model on the pin side
// Assumes: one request at a time from the bench
// Notes: pin hold is stretched to the write minimum
`timescale 1ns/1ps
module dtc_ctrl_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests
  input wire logic go,
  input wire logic wr,
  input wire logic bc4,
  input wire logic rd,
  input wire logic [7:0] hold,
  // towards the device
  output logic pin,
  output logic wcmd,
  output logic wbc4,
  output logic drv
);
  logic [7:0] cnt_reg;
  logic [7:0] need;
  assign need = wr ? (bc4 ? 8'h04 : 8'h06) : 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
      wcmd <= 1'b0;
    end else begin
      wcmd <= go && wr;
      if (go) begin
        cnt_reg <= (hold < need) ? need : hold;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
  assign pin = cnt_reg != 8'h00;
  assign wbc4 = bc4;
  // reads only while the pin is low
  assign drv = rd && !pin;
endmodule : dtc_ctrl_model

// ===== test/dtc_term_ctrl_assertions.sv
// Purpose: port checks of the termination control
// Assumes: latency below 70 cycles
// Notes: idle windows cover the longest latency
`timescale 1ns/1ps
module dtc_term_ctrl_assertions (
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic penable,
  input wire logic pwrite,
  // pin side and outputs
  input wire logic term_control_pin,
  input wire logic write_cmd,
  input wire logic drivers_active,
  input wire logic [2:0] term_lane_en,
  input wire logic write_strength_sel,
  input wire logic [2:0] nominal_termination,
  input wire logic [1:0] write_termination
);
  logic [6:0] low_reg;
  logic [6:0] idle_reg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_reg <= 7'h00;
      idle_reg <= 7'h00;
    end else begin
      low_reg <= term_control_pin ? 7'h00 : low_reg + 7'(low_reg < 7'h7f);
      idle_reg <= write_cmd ? 7'h00 : idle_reg + 7'(idle_reg < 7'h7f);
    end
  end
  AST_MODE_OFF:
    assert property (nominal_termination == 3'h0 && write_termination ==
      2'h0 |-> term_lane_en == 3'h0 && !write_strength_sel) else $error("mode");
  AST_LANES:
    assert property (term_lane_en inside {3'h0, 3'h7}) else $error("lanes");
  AST_WR_DYN:
    assert property (write_strength_sel |-> write_termination != 2'h0)
      else $error("dyn");
  AST_READ:
    assert property (drivers_active ##1 drivers_active |-> term_lane_en ==
      3'h0) else $error("read");
  AST_PIN_LOW:
    assert property (low_reg >= 7'h50 |-> term_lane_en == 3'h0)
      else $error("pin low");
  AST_IDLE_NOM:
    assert property (idle_reg >= 7'h50 |-> !write_strength_sel)
      else $error("idle");
  AST_WR_HOLD:
    assert property ($rose(write_strength_sel) |-> write_strength_sel[*4])
      else $error("strength");
  AST_NOM_APB:
    assert property (!$stable(nominal_termination) |-> $past(penable &&
      pwrite) || $past(penable && pwrite, 2)) else $error("nom");
endmodule : dtc_term_ctrl_assertions
bind dtc_term_ctrl dtc_term_ctrl_assertions dtc_term_ctrl_assertions_i (
  .pclk(pclk), .presetn(presetn), .penable(penable), .pwrite(pwrite),
  .term_control_pin(term_control_pin), .write_cmd(write_cmd),
  .drivers_active(drivers_active), .term_lane_en(term_lane_en),
  .write_strength_sel(write_strength_sel),
  .nominal_termination(nominal_termination),
  .write_termination(write_termination));

// ===== test/dtc_term_ctrl_bench.sv
// Purpose: self-checking bench of the termination control
// Assumes: controller model drives pin, writes and reads
// Notes: latencies compared with each other, not absolute
`timescale 1ns/1ps
`include "dtc_map.svh"
module dtc_term_ctrl_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic go, wr, bc4, rd, pin, wcmd, wbc4, drv, ws, viol;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] hold;
  logic [2:0] lane, nom;
  logic [1:0] wrt;
  int num_errors, n_compared, on_t, off_t, ws_n, base;
  dtc_term_ctrl dtc_term_ctrl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_control_pin(pin), .write_cmd(wcmd), .write_bc4(wbc4),
    .dll_locked(1'b1), .drivers_active(drv), .term_lane_en(lane),
    .write_strength_sel(ws), .nominal_termination(nom),
    .write_termination(wrt), .hold_violation(viol));
  dtc_ctrl_model dtc_ctrl_model_i (.pclk(pclk), .presetn(presetn),
    .go(go), .wr(wr), .bc4(bc4), .rd(rd), .hold(hold), .pin(pin),
    .wcmd(wcmd), .wbc4(wbc4), .drv(drv));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // pready is looked at between edges, where it stands settled
    for (i = 0; i < 20; i++) begin
      @(negedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      final_report();
    end
    {rdat, err} = {prdata, pslverr};
    @(posedge pclk);
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic pulse(input logic [7:0] h, input logic w, b);
    @(posedge pclk);
    {go, wr, bc4, hold} <= {1'b1, w, b, h};
    @(posedge pclk);
    go <= 1'b0;
    {on_t, off_t, ws_n} = {-32'sd1, -32'sd1, 32'sd0};
    for (int i = 0; i < 150; i++) begin
      @(negedge pclk);
      if (lane[0] === 1'b1 && on_t < 0) on_t = i;
      if (on_t >= 0 && lane[0] === 1'b0 && off_t < 0) off_t = i;
      if (ws === 1'b1) ws_n++;
    end
  endtask : pulse
  task automatic s_reset;
    apb(1'b0, `DTC_OFF_LAT, 32'h0);
    chk("lat", 32'h5, rdat);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    pulse(8'h08, 1'b0, 1'b0);
    chk("disabled", 32'hffffffff, on_t);
  endtask : s_reset
  task automatic s_latency;
    apb(1'b1, `DTC_OFF_MODE1, 32'h4);
    apb(1'b1, `DTC_OFF_MODE2, 32'h200);
    repeat (2) @(posedge pclk);
    chk("codes", 32'h5, {27'h0, nom, wrt});
    pulse(8'h08, 1'b0, 1'b0);
    chk("on span", 32'h8, off_t - on_t);
    base = on_t;
    apb(1'b1, `DTC_OFF_LAT, 32'h106);
    pulse(8'h08, 1'b0, 1'b0);
    chk("al shift", 32'h2, on_t - base);
  endtask : s_latency
  task automatic s_write;
    pulse(8'h08, 1'b1, 1'b1);
    chk("bc4 span", 32'h4, ws_n);
    pulse(8'h08, 1'b1, 1'b0);
    chk("bl8 span", 32'h6, ws_n);
  endtask : s_write
  task automatic s_sref;
    apb(1'b1, `DTC_OFF_CTRL, 32'h1);
    pulse(8'h08, 1'b0, 1'b0);
    chk("sref", 32'hffffffff, on_t);
    apb(1'b1, `DTC_OFF_CTRL, 32'h0);
    rd <= 1'b1;
    pulse(8'h00, 1'b0, 1'b0);
    rd <= 1'b0;
    pulse(8'h02, 1'b0, 1'b0);
    chk("short high", 32'h1, {31'h0, viol});
    apb(1'b1, `DTC_OFF_MODE2, 32'h0);
    apb(1'b1, `DTC_OFF_MODE1, 32'h0);
    pulse(8'h08, 1'b1, 1'b0);
    chk("mode off", 32'hffffffff, on_t);
    chk("mode off ws", 32'h0, ws_n);
  endtask : s_sref
  initial begin
    {presetn, psel, penable, pwrite, go, wr, bc4, rd} = 8'h00;
    {paddr, pwdata, hold} = 52'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_latency();
    s_write();
    s_sref();
    final_report();
  end
endmodule : dtc_term_ctrl_bench
